// *** rtl/flash_page_map_protect_decode.sv ***
// Array address decode, protection check, reset load and register block.
// Core bus and config read port are synchronous to clk_in; registers on AXI4-Lite.
`timescale 1ns/1ps
`include "flash_map_regs.svh"
module flash_page_map_protect_decode
(
    input  wire logic                         clk_in,
    input  wire logic                         arst_n_in,
    input  wire logic [7:0]                   s_axi_awaddr_in,
    input  wire logic                         s_axi_awvalid_in,
    output logic                              s_axi_awready_out,
    input  wire logic [31:0]                  s_axi_wdata_in,
    input  wire logic [3:0]                   s_axi_wstrb_in,
    input  wire logic                         s_axi_wvalid_in,
    output logic                              s_axi_wready_out,
    output logic [1:0]                        s_axi_bresp_out,
    output logic                              s_axi_bvalid_out,
    input  wire logic                         s_axi_bready_in,
    input  wire logic [7:0]                   s_axi_araddr_in,
    input  wire logic                         s_axi_arvalid_in,
    output logic                              s_axi_arready_out,
    output logic [31:0]                       s_axi_rdata_out,
    output logic [1:0]                        s_axi_rresp_out,
    output logic                              s_axi_rvalid_out,
    input  wire logic                         s_axi_rready_in,
    input  wire flash_map_pkg::logical_addr_t core_addr_in,
    input  wire flash_map_pkg::byte_t         page_select_register_in,
    input  wire logic                         core_valid_in,
    input  wire logic                         core_write_in,
    output logic                              core_hold_out,
    output logic                              array_sel_out,
    output flash_map_pkg::array_addr_t        array_rel_addr_out,
    output logic                              region_protected_out,
    output logic                              prot_violation_out,
    output logic                              key_area_out,
    output logic                              cfg_rd_req_out,
    output flash_map_pkg::array_addr_t        cfg_rd_addr_out,
    input  wire flash_map_pkg::byte_t         cfg_rd_data_in,
    input  wire logic                         cfg_rd_ack_in
);
    import flash_map_pkg::*;

    function automatic logic [3:0] reg_index(input logic [7:0] a);
        return a[5:2];
    endfunction

    function automatic logic reg_mapped(input logic [7:0] a);
        return (a[7:6] == 2'h0) && (a[1:0] == 2'h0);
    endfunction

    // Reset release
    logic rst_meta;
    logic rst_n;
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // Reset load of protection and security
    load_state_t load_state, next_load_state;
    byte_t       region_protection_cfg, next_region_protection_cfg;
    byte_t       security_state, next_security_state;
    logic        next_cfg_rd_req;
    array_addr_t next_cfg_rd_addr;
    logic        do_write;
    logic [3:0]  wr_idx;
    logic [31:0] wr_data;

    always_comb
    begin
        next_load_state            = load_state;
        next_region_protection_cfg = region_protection_cfg;
        next_security_state        = security_state;
        case (load_state)
            LOAD_PROT:
                if (cfg_rd_req_out && cfg_rd_ack_in)
                begin
                    next_region_protection_cfg = cfg_rd_data_in;
                    next_load_state            = LOAD_SEC;
                end
            LOAD_SEC:
                if (cfg_rd_req_out && cfg_rd_ack_in)
                begin
                    next_security_state = cfg_rd_data_in;
                    next_load_state     = LOAD_DONE;
                end
            default:
                if (do_write && wr_idx == `PROT_IDX)
                    next_region_protection_cfg = wr_data[7:0];
        endcase
        next_cfg_rd_req  = (next_load_state != LOAD_DONE);
        next_cfg_rd_addr = (next_load_state == LOAD_PROT) ? `PROT_BYTE_REL : `SEC_BYTE_REL;
    end

    always_ff @(posedge clk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            load_state            <= LOAD_PROT;
            region_protection_cfg <= 8'hff;
            security_state        <= 8'hff;
            cfg_rd_req_out        <= 1'b0;
            cfg_rd_addr_out       <= `PROT_BYTE_REL;
            core_hold_out         <= 1'b1;
        end
        else
        begin
            load_state            <= next_load_state;
            region_protection_cfg <= next_region_protection_cfg;
            security_state        <= next_security_state;
            cfg_rd_req_out        <= next_cfg_rd_req;
            cfg_rd_addr_out       <= next_cfg_rd_addr;
            core_hold_out         <= (next_load_state != LOAD_DONE);
        end
    end

    // Core access decode
    logic        win_hit;
    logic        win_top;
    logic [13:0] win_offset;
    logic        area_protected;
    logic        core_take;
    logic        next_violation;

    page_window_decode u_window
    (
        .addr_in    (core_addr_in),
        .page_in    (page_select_register_in),
        .hit_out    (win_hit),
        .top_out    (win_top),
        .offset_out (win_offset)
    );

    protect_region_check u_protect
    (
        .top_in        (win_top),
        .offset_in     (win_offset),
        .cfg_in        (region_protection_cfg),
        .protected_out (area_protected)
    );

    assign core_take      = core_valid_in && !core_hold_out;
    assign next_violation = core_take && core_write_in && win_hit && area_protected;

    always_ff @(posedge clk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            array_sel_out        <= 1'b0;
            array_rel_addr_out   <= `BOTTOM_REL_BASE;
            region_protected_out <= 1'b0;
            prot_violation_out   <= 1'b0;
            key_area_out         <= 1'b0;
        end
        else
        begin
            array_sel_out        <= core_take && win_hit;
            array_rel_addr_out   <= {win_top ? `TOP_REL_BASE : `BOTTOM_REL_BASE}
                                    | {3'h0, win_offset};
            region_protected_out <= core_take && win_hit && area_protected;
            prot_violation_out   <= next_violation;
            key_area_out         <= core_take && (core_addr_in >= `KEY_FIRST)
                                    && (core_addr_in <= `KEY_LAST);
        end
    end

    // Register bus: write channel
    logic       aw_held, next_aw_held;
    logic       w_held, next_w_held;
    logic [7:0] awaddr_q, next_awaddr;
    logic [31:0] wdata_q, next_wdata;
    logic       wstrb0_q, next_wstrb0;
    logic       next_bvalid;
    logic [1:0] next_bresp;
    byte_t      clock_divider_cfg, next_clock_divider_cfg;
    byte_t      irq_enable_key_config, next_irq_enable_key_config;
    byte_t      operation_command_code, next_operation_command_code;
    logic       pviol_flag, next_pviol_flag;

    assign wr_idx  = reg_index(awaddr_q);
    assign wr_data = wdata_q;

    always_comb
    begin
        do_write     = aw_held && w_held && !s_axi_bvalid_out && reg_mapped(awaddr_q)
                       && wstrb0_q;
        next_aw_held = aw_held;
        next_w_held  = w_held;
        next_awaddr  = awaddr_q;
        next_wdata   = wdata_q;
        next_wstrb0  = wstrb0_q;
        next_bvalid  = s_axi_bvalid_out && !s_axi_bready_in;
        next_bresp   = s_axi_bresp_out;
        if (s_axi_awvalid_in && s_axi_awready_out)
        begin
            next_aw_held = 1'b1;
            next_awaddr  = s_axi_awaddr_in;
        end
        if (s_axi_wvalid_in && s_axi_wready_out)
        begin
            next_w_held = 1'b1;
            next_wdata  = s_axi_wdata_in;
            next_wstrb0 = s_axi_wstrb_in[0];
        end
        if (aw_held && w_held && !s_axi_bvalid_out)
        begin
            next_aw_held = 1'b0;
            next_w_held  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = reg_mapped(awaddr_q) ? `RESP_OKAY : `RESP_DECERR;
        end
        next_clock_divider_cfg      = clock_divider_cfg;
        next_irq_enable_key_config  = irq_enable_key_config;
        next_operation_command_code = operation_command_code;
        // Set wins over a clear in the same cycle
        next_pviol_flag = pviol_flag || next_violation;
        if (do_write)
            case (wr_idx)
                `CLKDIV_IDX:
                    if (!clock_divider_cfg[`CLKDIV_LOADED_BIT])
                        next_clock_divider_cfg = {1'b1, wr_data[6:0]};
                `KEYCFG_IDX: next_irq_enable_key_config = wr_data[7:0] & `KEYCFG_WMASK;
                `CMD_IDX:    next_operation_command_code = wr_data[7:0] & `CMD_WMASK;
                `STATUS_IDX:
                    if (wr_data[`STATUS_PVIOL_BIT])
                        next_pviol_flag = next_violation;
                default: next_pviol_flag = next_pviol_flag;
            endcase
    end

    always_ff @(posedge clk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            aw_held                <= 1'b0;
            w_held                 <= 1'b0;
            awaddr_q               <= 8'h00;
            wdata_q                <= 32'h0000_0000;
            wstrb0_q               <= 1'b0;
            s_axi_bvalid_out       <= 1'b0;
            s_axi_bresp_out        <= `RESP_OKAY;
            s_axi_awready_out      <= 1'b0;
            s_axi_wready_out       <= 1'b0;
            clock_divider_cfg      <= 8'h00;
            irq_enable_key_config  <= 8'h00;
            operation_command_code <= 8'h00;
            pviol_flag             <= 1'b0;
        end
        else
        begin
            aw_held                <= next_aw_held;
            w_held                 <= next_w_held;
            awaddr_q               <= next_awaddr;
            wdata_q                <= next_wdata;
            wstrb0_q               <= next_wstrb0;
            s_axi_bvalid_out       <= next_bvalid;
            s_axi_bresp_out        <= next_bresp;
            s_axi_awready_out      <= !next_aw_held && !next_bvalid;
            s_axi_wready_out       <= !next_w_held && !next_bvalid;
            clock_divider_cfg      <= next_clock_divider_cfg;
            irq_enable_key_config  <= next_irq_enable_key_config;
            operation_command_code <= next_operation_command_code;
            pviol_flag             <= next_pviol_flag;
        end
    end

    // Register bus: read channel
    logic        next_rvalid;
    logic [31:0] next_rdata;
    logic [1:0]  next_rresp;
    byte_t       rd_byte;

    always_comb
    begin
        case (reg_index(s_axi_araddr_in))
            `CLKDIV_IDX:   rd_byte = clock_divider_cfg;
            `SECURITY_IDX: rd_byte = security_state;
            `KEYCFG_IDX:   rd_byte = irq_enable_key_config;
            `PROT_IDX:     rd_byte = region_protection_cfg;
            `STATUS_IDX:   rd_byte = `STATUS_FIXED | {2'h0, pviol_flag, 5'h00};
            `CMD_IDX:      rd_byte = operation_command_code;
            default:       rd_byte = 8'h00;
        endcase
        next_rvalid = s_axi_rvalid_out && !s_axi_rready_in;
        next_rdata  = s_axi_rdata_out;
        next_rresp  = s_axi_rresp_out;
        if (s_axi_arvalid_in && s_axi_arready_out)
        begin
            next_rvalid = 1'b1;
            next_rdata  = reg_mapped(s_axi_araddr_in) ? {24'h00_0000, rd_byte} : 32'h0;
            next_rresp  = reg_mapped(s_axi_araddr_in) ? `RESP_OKAY : `RESP_DECERR;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_axi_rvalid_out  <= 1'b0;
            s_axi_rdata_out   <= 32'h0000_0000;
            s_axi_rresp_out   <= `RESP_OKAY;
            s_axi_arready_out <= 1'b0;
        end
        else
        begin
            s_axi_rvalid_out  <= next_rvalid;
            s_axi_rdata_out   <= next_rdata;
            s_axi_rresp_out   <= next_rresp;
            s_axi_arready_out <= !next_rvalid;
        end
    end

    // Checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n);

    property p_below_window;
        core_valid_in && (core_addr_in[15:14] == 2'h0) |=> !array_sel_out;
    endproperty
    a_below_window: assert property (p_below_window)
        else $error("array selected below window");

    property p_bad_page;
        core_take && (core_addr_in[15:14] == `WIN_PAGED)
        && (page_select_register_in[7:1] != 7'h1f) |=> !array_sel_out;
    endproperty
    a_bad_page: assert property (p_bad_page)
        else $error("unimplemented page selected array");

    property p_paged_map;
        core_take && (core_addr_in[15:14] == `WIN_PAGED)
        && (page_select_register_in == `PAGE_BOTTOM)
        |=> array_sel_out && (array_rel_addr_out == ({3'h6, $past(core_addr_in[13:0])}));
    endproperty
    a_paged_map: assert property (p_paged_map)
        else $error("bottom page not seen in middle window");

    property p_fixed_top;
        core_take && (core_addr_in[15:14] == `WIN_FIXED_HI)
        |=> array_sel_out && (array_rel_addr_out[16:14] == 3'h7);
    endproperty
    a_fixed_top: assert property (p_fixed_top)
        else $error("top fixed window misplaced");

    property p_whole_protect;
        core_take && win_hit && (region_protection_cfg == 8'h24)
        |=> region_protected_out;
    endproperty
    a_whole_protect: assert property (p_whole_protect)
        else $error("whole array not protected");

    property p_low_open;
        core_take && (region_protection_cfg[7] == 1'b0) && (region_protection_cfg[2:0] == 3'h3)
        && (core_addr_in >= 16'h4000) && (core_addr_in <= 16'h5fff) |=> !region_protected_out;
    endproperty
    a_low_open: assert property (p_low_open)
        else $error("lower area not left open");

    property p_high_prot;
        core_take && region_protection_cfg[7] && (region_protection_cfg[5:3] == 3'h0)
        && (core_addr_in >= 16'hf800) |=> region_protected_out;
    endproperty
    a_high_prot: assert property (p_high_prot)
        else $error("higher area not protected");

    property p_key_area;
        core_take && (core_addr_in[15:3] == 13'h1fe0) |=> key_area_out;
    endproperty
    a_key_area: assert property (p_key_area)
        else $error("key area not flagged");

    property p_hold_load;
        (load_state != LOAD_DONE) |-> core_hold_out && !array_sel_out;
    endproperty
    a_hold_load: assert property (p_hold_load)
        else $error("core not held during load");

    property p_sec_load;
        (load_state == LOAD_SEC) && cfg_rd_req_out && cfg_rd_ack_in
        |=> security_state == $past(cfg_rd_data_in) ##1 $stable(security_state)[*3];
    endproperty
    a_sec_load: assert property (p_sec_load)
        else $error("security byte not captured once");

    property p_rsvd_read;
        s_axi_arvalid_in && s_axi_arready_out && (s_axi_araddr_in == 8'h08)
        |=> s_axi_rvalid_out && (s_axi_rdata_out == 32'h0);
    endproperty
    a_rsvd_read: assert property (p_rsvd_read)
        else $error("reserved register read non-zero");

    c_load_done:  cover property ((load_state == LOAD_SEC) ##1 (load_state == LOAD_DONE));
    c_violation:  cover property (prot_violation_out ##[1:4] pviol_flag);
    c_paged_top:  cover property (array_sel_out && array_rel_addr_out[16:14] == 3'h7);
    c_write_resp: cover property (s_axi_bvalid_out && s_axi_bready_in);
endmodule // flash_page_map_protect_decode

// *** rtl/flash_map_regs.svh ***
// Offsets, field positions and fixed values of the array decode block.
// Included by the package user files; definitions only.
`ifndef FLASH_MAP_REGS_SVH
`define FLASH_MAP_REGS_SVH

// Register indices; byte address is four times the index
`define CLKDIV_IDX      4'h0
`define SECURITY_IDX    4'h1
`define RSVD_ONE_IDX    4'h2
`define KEYCFG_IDX      4'h3
`define PROT_IDX        4'h4
`define STATUS_IDX      4'h5
`define CMD_IDX         4'h6

// Logical windows, taken from address bits 15:14
`define WIN_FIXED_LO    2'h1
`define WIN_PAGED       2'h2
`define WIN_FIXED_HI    2'h3
`define PAGE_BOTTOM     8'h3e
`define PAGE_TOP        8'h3f
`define BOTTOM_REL_BASE 17'h18000
`define TOP_REL_BASE    17'h1c000

// Configuration field
`define KEY_FIRST       16'hff00
`define KEY_LAST        16'hff07
`define PROT_BYTE_REL   17'h1ff0d
`define SEC_BYTE_REL    17'h1ff0f

// Protection byte fields
`define PROT_OPEN_BIT   7
`define PROT_HDIS_BIT   5
`define PROT_HS_HI      4
`define PROT_HS_LO      3
`define PROT_LDIS_BIT   2
`define PROT_LS_HI      1
`define PROT_LS_LO      0
`define LOW_SIZE0       14'h0400
`define LOW_SIZE1       14'h0800
`define LOW_SIZE2       14'h1000
`define LOW_SIZE3       14'h2000
`define HIGH_START0     14'h3800
`define HIGH_START1     14'h3000
`define HIGH_START2     14'h2000
`define HIGH_START3     14'h0000

// Register fields and masks
`define CLKDIV_LOADED_BIT 7
`define CLKDIV_WMASK    8'h7f
`define KEYCFG_WMASK    8'he0
`define CMD_WMASK       8'h65
`define STATUS_FIXED    8'hc0
`define STATUS_PVIOL_BIT 5
`define RESP_OKAY       2'h0
`define RESP_DECERR     2'h3

`endif

// *** rtl/flash_map_pkg.sv ***
// Types shared by the array decode block.
// No assumptions beyond a SystemVerilog compiler.
package flash_map_pkg;
    typedef logic [15:0] logical_addr_t;
    typedef logic [7:0]  byte_t;
    typedef logic [16:0] array_addr_t;
    typedef enum logic [1:0] {LOAD_PROT, LOAD_SEC, LOAD_DONE} load_state_t;
endpackage

// *** rtl/page_window_decode.sv ***
// Maps a logical core address and page number onto one of the two array pages.
// Purely combinational; the caller registers the results.
`timescale 1ns/1ps
`include "flash_map_regs.svh"
module page_window_decode
(
    input  wire logic [15:0] addr_in,
    input  wire logic [7:0]  page_in,
    output logic             hit_out,
    output logic             top_out,
    output logic [13:0]      offset_out
);
    always_comb
    begin
        hit_out    = 1'b0;
        top_out    = 1'b0;
        offset_out = addr_in[13:0];
        case (addr_in[15:14])
            `WIN_FIXED_LO: hit_out = 1'b1;
            `WIN_FIXED_HI:
            begin
                hit_out = 1'b1;
                top_out = 1'b1;
            end
            `WIN_PAGED:
            begin
                hit_out = (page_in == `PAGE_BOTTOM) || (page_in == `PAGE_TOP);
                top_out = (page_in == `PAGE_TOP);
            end
            default: hit_out = 1'b0;
        endcase
    end
endmodule // page_window_decode

// *** rtl/protect_region_check.sv ***
// Decides whether a page offset lies in a protected area.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps
`include "flash_map_regs.svh"
module protect_region_check
(
    input  wire logic        top_in,
    input  wire logic [13:0] offset_in,
    input  wire logic [7:0]  cfg_in,
    output logic             protected_out
);
    logic [13:0] low_size;
    logic [13:0] high_start;
    logic        low_area;
    logic        high_area;

    always_comb
    begin
        case (cfg_in[`PROT_LS_HI:`PROT_LS_LO])
            2'h0:    low_size = `LOW_SIZE0;
            2'h1:    low_size = `LOW_SIZE1;
            2'h2:    low_size = `LOW_SIZE2;
            default: low_size = `LOW_SIZE3;
        endcase
        case (cfg_in[`PROT_HS_HI:`PROT_HS_LO])
            2'h0:    high_start = `HIGH_START0;
            2'h1:    high_start = `HIGH_START1;
            2'h2:    high_start = `HIGH_START2;
            default: high_start = `HIGH_START3;
        endcase
        low_area  = !top_in && (offset_in < low_size) && !cfg_in[`PROT_LDIS_BIT];
        high_area = top_in && (offset_in >= high_start) && !cfg_in[`PROT_HDIS_BIT];
        // Open: enabled areas protected; closed: all but enabled areas
        if (cfg_in[`PROT_OPEN_BIT])
            protected_out = low_area || high_area;
        else
            protected_out = !(low_area || high_area);
    end
endmodule // protect_region_check

// *** dv/cfg_array_model.sv ***
// Config field read port model for the reset load.
// Assumes req holds until ack, as the load sequence does.
`timescale 1ns/1ps
module cfg_array_model
#(
    parameter logic [7:0] prot_byte = 8'h24,
    parameter logic [7:0] sec_byte  = 8'h5a
)
(
    input  wire logic        clk_in,
    input  wire logic        req_in,
    input  wire logic [16:0] addr_in,
    output logic [7:0]       data_out,
    output logic             ack_out
);
    int         wait_n = 0;
    logic [7:0] last   = 8'h00;
    logic [7:0] data_q = 8'h00;
    logic       ack_q  = 1'b0;
    assign data_out = data_q;
    assign ack_out  = ack_q;
    always @(posedge clk_in)
    begin
        // Slow for the first byte, prompt for the second
        if (req_in && !ack_q && wait_n >= (addr_in[1] ? 0 : 3))
        begin
            wait_n <= 0;
            last   <= addr_in[1] ? sec_byte : prot_byte;
            ack_q  <= 1'b1;
            data_q <= addr_in[1] ? sec_byte : prot_byte;
        end
        else
        begin
            ack_q  <= 1'b0;
            // Stale data never repeats the last byte
            data_q <= ~last;
            if (req_in && !ack_q)
                wait_n <= wait_n + 1;
        end
    end
endmodule // cfg_array_model

// *** dv/flash_page_map_protect_decode_test.sv ***
// Self-checking bench for the array decode block.
// Drives AXI4-Lite and the core bus; integer model gives expectations.
`timescale 1ns/1ps
`include "flash_map_regs.svh"
`define chk(n, e, s) begin checks++; if ((e) !== (s)) begin bad_count++; \
    $display("[ERR] %s exp %h got %h", n, e, s); end end
module flash_page_map_protect_decode_test;
    import flash_map_pkg::*;
    logic        clk = 0, rst_n = 0, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
    logic        cvalid = 0, cwrite = 0, awready, wready, bvalid, arready, rvalid;
    logic        hold, sel, prot_o, viol, key, creq, cack;
    logic [7:0]  awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata;
    logic [15:0] caddr = 0;
    logic [1:0]  bresp, rresp, r, wb;
    byte_t       page = 0, cfg_data, p, d, e;
    array_addr_t rel, cfg_addr;
    int          bad_count = 0, checks = 0, seed = 21, i, j;
    logic [15:0] tbl [8] = '{16'h43ff, 16'h4400, 16'h5fff, 16'h8000,
                             16'hb7ff, 16'hf800, 16'h3fff, 16'hff07};
    flash_page_map_protect_decode DUT (.clk_in(clk), .arst_n_in(rst_n),
        .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awv), .s_axi_awready_out(awready),
        .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'h1), .s_axi_wvalid_in(wv),
        .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
        .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arv),
        .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
        .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .core_addr_in(caddr),
        .page_select_register_in(page), .core_valid_in(cvalid), .core_write_in(cwrite),
        .core_hold_out(hold), .array_sel_out(sel), .array_rel_addr_out(rel),
        .region_protected_out(prot_o), .prot_violation_out(viol), .key_area_out(key),
        .cfg_rd_req_out(creq), .cfg_rd_addr_out(cfg_addr), .cfg_rd_data_in(cfg_data),
        .cfg_rd_ack_in(cack));
    cfg_array_model array_model (.clk_in(clk), .req_in(creq), .addr_in(cfg_addr),
        .data_out(cfg_data), .ack_out(cack));
    initial forever #10 clk = ~clk;
    task automatic wr(input int a, input byte_t v);
        awaddr <= 8'(a); wdata <= {24'h0, v}; awv <= 1; wv <= 1; bready <= 1;
        forever begin
            @(posedge clk);
            if (awready) awv <= 0;
            if (wready) wv <= 0;
            if (bvalid) break;
        end
        wb = bresp;
        bready <= 0;
        @(posedge clk);
    endtask
    task automatic rd(input int a, output byte_t v, output logic [1:0] rs);
        araddr <= 8'(a); arv <= 1; rready <= 1;
        forever begin
            @(posedge clk);
            if (arready) arv <= 0;
            if (rvalid) break;
        end
        v = rdata[7:0]; rs = rresp; rready <= 0;
        @(posedge clk);
    endtask
    task automatic acc(input logic [15:0] a, input byte_t pg, input logic w);
        int hit, top, off, lo, hi, pr;
        caddr <= a; page <= pg; cwrite <= w; cvalid <= 1;
        @(posedge clk);
        cvalid <= 0;
        #1;
        off = a[13:0];
        top = a[15] & (a[14] | pg == 8'h3f);
        hit = a[15:14] == 1 || a[15:14] == 3 || (a[15:14] == 2 && pg[7:1] == 7'h1f);
        lo = !top && !p[2] && off < (32'h400 << p[1:0]);
        hi = top && !p[5] && off >= 32'h4000 - (32'h800 << p[4:3]);
        pr = hit && (p[7] ? lo || hi : !(lo || hi));
        `chk("sel", hit[0], sel)
        if (hit)
            `chk("rel", array_addr_t'(32'h18000 + top * 32'h4000 + off), rel)
        `chk("prot", pr[0], prot_o)
        `chk("viol", pr[0] & w, viol)
        `chk("key", logic'(a >= 16'hff00 && a <= 16'hff07), key)
        @(posedge clk);
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        #400000;
        bad_count++;
        $display("[ERR] watchdog exp done got hang");
        stop_test;
    end
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1;
        repeat (3) @(posedge clk);
        caddr <= 16'hc000; cvalid <= 1;
        repeat (2) @(posedge clk);
        cvalid <= 0;
        #1;
        `chk("held", 1'b0, sel)
        for (i = 0; i < 100 && hold !== 1'b0; i++) @(posedge clk);
        `chk("hold", 1'b0, hold)
        rd(4 * `PROT_IDX, d, r);
        `chk("prot_reg", 8'h24, d)
        rd(4 * `SECURITY_IDX, d, r);
        `chk("sec_reg", 8'h5a, d)
        $display("reset test end");
        for (i = 0; i < 16; i++) begin
            wr(4 * i, 8'hff);
            rd(4 * i, d, r);
            case (i) 0, 4: e = 8'hff; 1: e = 8'h5a; 3: e = 8'he0; 5: e = 8'hc0;
                6: e = 8'h65; default: e = 8'h00; endcase
            `chk("reg", e, d)
            `chk("bresp", `RESP_OKAY, wb)
            `chk("rresp", `RESP_OKAY, r)
        end
        wr(8'h40, 8'hff);
        `chk("wr_decerr", `RESP_DECERR, wb)
        rd(8'h40, d, r);
        `chk("decerr", `RESP_DECERR, r)
        $display("register test end");
        for (i = 0; i < 12; i++) begin
            p = (i == 0) ? 8'h24 : 8'($random(seed));
            wr(4 * `PROT_IDX, p);
            for (j = 0; j < 16; j++)
                acc(j < 8 ? tbl[j] : 16'($random(seed)),
                    j % 3 == 0 ? 8'h3e : j % 3 == 1 ? 8'h3f : 8'($random(seed)),
                    1'($random(seed)));
        end
        $display("decode test end");
        rst_n <= 0;
        repeat (2) @(posedge clk);
        rst_n <= 1;
        for (i = 0; i < 100 && hold !== 1'b0; i++) @(posedge clk);
        `chk("rehold", 1'b0, hold)
        rd(4 * `PROT_IDX, d, r);
        `chk("prot_reload", 8'h24, d)
        $display("second reset test end");
        stop_test;
    end
endmodule // flash_page_map_protect_decode_test
